// *** logic/pssi_evt_latch.sv ***
// bank of latched-high event bits cleared by a register read
`timescale 1ns/1ps
module pssi_evt_latch
  import pssi_pkg::*;
#(
  parameter int W = 3
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [W-1:0] evt,
  input wire logic clr,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] bits;
  } pssi_lat_s;

  pssi_lat_s st_r;
  pssi_lat_s st_nxt;

  // ----------------------------------------------------------------
  // per-bit latch
  // ----------------------------------------------------------------
  logic [W-1:0] bit_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      // set beats clear so an event in the read cycle survives
      assign bit_nxt[gi] = evt[gi] | (st_r.bits[gi] & ~clr);
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    st_nxt.bits = bit_nxt;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.bits;

endmodule : pssi_evt_latch

// *** logic/pssi_pkg.sv ***
// constants for the port status summary and event interrupt block
package pssi_pkg;

  // ----------------------------------------------------------------
  // register addresses in the management space
  // ----------------------------------------------------------------
  localparam logic [4:0] PSSI_ADDR_SUMMARY = 5'h19;
  localparam logic [4:0] PSSI_ADDR_EVT_CTL = 5'h1A;

  // ----------------------------------------------------------------
  // status_summary field positions
  // ----------------------------------------------------------------
  localparam int PSSI_SUM_AN_DONE = 15;
  localparam int PSSI_SUM_CMPL_ACK = 14;
  localparam int PSSI_SUM_ACK_DET = 13;
  localparam int PSSI_SUM_ABIL_DET = 12;
  localparam int PSSI_SUM_PAUSE = 11;
  localparam int PSSI_SUM_MODE_HI = 10;
  localparam int PSSI_SUM_MODE_LO = 8;
  localparam int PSSI_SUM_PD_FAULT = 7;
  localparam int PSSI_SUM_REM_FAULT = 6;
  localparam int PSSI_SUM_PAGE_RX = 5;
  localparam int PSSI_SUM_LP_AN_ABLE = 4;
  localparam int PSSI_SUM_SPEED = 3;
  localparam int PSSI_SUM_LINK = 2;
  localparam int PSSI_SUM_AN_EN = 1;
  localparam int PSSI_SUM_DUPLEX = 0;

  // ----------------------------------------------------------------
  // event_control_status field positions
  // ----------------------------------------------------------------
  localparam int PSSI_EVT_DUP_LED = 15;
  localparam int PSSI_EVT_MODE_EN = 14;
  localparam int PSSI_EVT_DUP_MASK = 11;
  localparam int PSSI_EVT_SPEED_CHANGE_MASK = 10;
  localparam int PSSI_EVT_LINK_MASK = 9;
  localparam int PSSI_EVT_MASTER = 8;
  localparam int PSSI_EVT_GLOBAL = 4;
  localparam int PSSI_EVT_DUP_CHG = 3;
  localparam int PSSI_EVT_SPD_CHG = 2;
  localparam int PSSI_EVT_LINK_CHG = 1;
  localparam int PSSI_EVT_IRQ_STAT = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic PSSI_RST_DUP_LED = 1'b0;
  localparam logic PSSI_RST_MODE_EN = 1'b0;
  localparam logic PSSI_RST_MASK = 1'b1;
  localparam logic PSSI_RST_MASTER = 1'b1;
  localparam logic PSSI_RST_LIVE = 1'b0;
  localparam logic [15:0] PSSI_RST_RDATA = 16'h0000;

  // widths of the two latched-high groups
  localparam int PSSI_SUM_LH_W = 5;
  localparam int PSSI_CHG_W = 3;

endpackage : pssi_pkg

// *** logic/pssi_status_irq.sv ***
// status summary and event interrupt registers of one port
`timescale 1ns/1ps
module pssi_status_irq
  import pssi_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic mgmt_rd,
  input wire logic mgmt_wr,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  input wire logic an_done,
  input wire logic an_cmpl_ack_evt,
  input wire logic an_ack_det_evt,
  input wire logic an_abil_det,
  input wire logic local_pause,
  input wire logic partner_pause,
  input wire logic [2:0] best_common_mode,
  input wire logic pd_fault_evt,
  input wire logic partner_remote_fault,
  input wire logic page_rx_evt,
  input wire logic partner_an_able,
  input wire logic speed_100,
  input wire logic link_up,
  input wire logic an_enabled,
  input wire logic full_duplex,
  input wire logic other_irq,
  output logic irq_out_n,
  output logic duplex_led_in_stream,
  output logic irq_mode_enable
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic link_ll;
    logic prev_dup;
    logic prev_spd;
    logic prev_link;
    logic dup_led;
    logic mode_en;
    logic dup_mask;
    logic speed_change_mask;
    logic link_mask;
    logic master_mask;
    logic irq_n;
    logic [15:0] rdata;
  } pssi_state_s;

  pssi_state_s st_r;
  pssi_state_s st_nxt;

  logic rd_sum;
  logic rd_evt;
  logic wr_evt;
  logic [PSSI_SUM_LH_W-1:0] sum_lh;
  logic [PSSI_CHG_W-1:0] chg;
  logic [PSSI_CHG_W-1:0] chg_evt;
  logic [PSSI_CHG_W-1:0] chg_mask;
  logic irq_stat;
  logic [15:0] sum_word;
  logic [15:0] evt_word;

  assign rd_sum = mgmt_rd && (mgmt_addr == PSSI_ADDR_SUMMARY);
  assign rd_evt = mgmt_rd && (mgmt_addr == PSSI_ADDR_EVT_CTL);
  assign wr_evt = mgmt_wr && (mgmt_addr == PSSI_ADDR_EVT_CTL);

  // ----------------------------------------------------------------
  // latched-high summary events
  // ----------------------------------------------------------------
  // order: complete-ack, ack seen, ability detect, pd fault, page rx
  pssi_evt_latch #(
    .W(PSSI_SUM_LH_W)
  ) u_sum_lh (
    .mclk(mclk),
    .rstn(rstn),
    .evt({an_cmpl_ack_evt, an_ack_det_evt, an_abil_det, pd_fault_evt,
          page_rx_evt}),
    .clr(rd_sum),
    .q(sum_lh)
  );

  // ----------------------------------------------------------------
  // change detection: duplex, speed, link
  // ----------------------------------------------------------------
  assign chg_evt = {full_duplex != st_r.prev_dup,
                    speed_100 != st_r.prev_spd,
                    link_up != st_r.prev_link};

  pssi_evt_latch #(
    .W(PSSI_CHG_W)
  ) u_chg (
    .mclk(mclk),
    .rstn(rstn),
    .evt(chg_evt),
    .clr(rd_evt),
    .q(chg)
  );

  assign chg_mask = {st_r.dup_mask, st_r.speed_change_mask, st_r.link_mask};

  // unmasked change bits only reach the pin in interrupt mode with the master mask clear
  assign irq_stat = st_r.mode_en && !st_r.master_mask
                    && |(chg & ~chg_mask);

  // ----------------------------------------------------------------
  // read words
  // ----------------------------------------------------------------
  always_comb begin
    sum_word = 16'h0000;
    sum_word[PSSI_SUM_AN_DONE] = an_done;
    sum_word[PSSI_SUM_CMPL_ACK] = sum_lh[4];
    sum_word[PSSI_SUM_ACK_DET] = sum_lh[3];
    sum_word[PSSI_SUM_ABIL_DET] = sum_lh[2];
    sum_word[PSSI_SUM_PAUSE] = local_pause & partner_pause;
    sum_word[PSSI_SUM_MODE_HI:PSSI_SUM_MODE_LO] = best_common_mode;
    sum_word[PSSI_SUM_PD_FAULT] = sum_lh[1];
    sum_word[PSSI_SUM_REM_FAULT] = partner_remote_fault;
    sum_word[PSSI_SUM_PAGE_RX] = sum_lh[0];
    sum_word[PSSI_SUM_LP_AN_ABLE] = partner_an_able;
    sum_word[PSSI_SUM_SPEED] = speed_100;
    sum_word[PSSI_SUM_LINK] = st_r.link_ll;
    sum_word[PSSI_SUM_AN_EN] = an_enabled;
    sum_word[PSSI_SUM_DUPLEX] = full_duplex;
  end

  // reserved fields read zero
  always_comb begin
    evt_word = 16'h0000;
    evt_word[PSSI_EVT_DUP_LED] = st_r.dup_led;
    evt_word[PSSI_EVT_MODE_EN] = st_r.mode_en;
    evt_word[PSSI_EVT_DUP_MASK] = st_r.dup_mask;
    evt_word[PSSI_EVT_SPEED_CHANGE_MASK] = st_r.speed_change_mask;
    evt_word[PSSI_EVT_LINK_MASK] = st_r.link_mask;
    evt_word[PSSI_EVT_MASTER] = st_r.master_mask;
    evt_word[PSSI_EVT_GLOBAL] = irq_stat | other_irq;
    evt_word[PSSI_EVT_DUP_CHG] = chg[2];
    evt_word[PSSI_EVT_SPD_CHG] = chg[1];
    evt_word[PSSI_EVT_LINK_CHG] = chg[0];
    evt_word[PSSI_EVT_IRQ_STAT] = irq_stat;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.prev_dup = full_duplex;
    st_nxt.prev_spd = speed_100;
    st_nxt.prev_link = link_up;
    // a read reloads the live level, otherwise any loss sticks
    if (rd_sum) begin
      st_nxt.link_ll = link_up;
    end else begin
      st_nxt.link_ll = st_r.link_ll & link_up;
    end
    if (wr_evt) begin
      st_nxt.dup_led = mgmt_wdata[PSSI_EVT_DUP_LED];
      st_nxt.mode_en = mgmt_wdata[PSSI_EVT_MODE_EN];
      st_nxt.dup_mask = mgmt_wdata[PSSI_EVT_DUP_MASK];
      st_nxt.speed_change_mask = mgmt_wdata[PSSI_EVT_SPEED_CHANGE_MASK];
      st_nxt.link_mask = mgmt_wdata[PSSI_EVT_LINK_MASK];
      st_nxt.master_mask = mgmt_wdata[PSSI_EVT_MASTER];
    end
    // pin lags the status bit by one edge so it comes from a flop
    st_nxt.irq_n = ~irq_stat;
    if (rd_sum) begin
      st_nxt.rdata = sum_word;
    end else if (rd_evt) begin
      st_nxt.rdata = evt_word;
    end else if (mgmt_rd) begin
      st_nxt.rdata = 16'h0000;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r.link_ll <= PSSI_RST_LIVE;
      st_r.prev_dup <= PSSI_RST_LIVE;
      st_r.prev_spd <= PSSI_RST_LIVE;
      st_r.prev_link <= PSSI_RST_LIVE;
      st_r.dup_led <= PSSI_RST_DUP_LED;
      st_r.mode_en <= PSSI_RST_MODE_EN;
      st_r.dup_mask <= PSSI_RST_MASK;
      st_r.speed_change_mask <= PSSI_RST_MASK;
      st_r.link_mask <= PSSI_RST_MASK;
      st_r.master_mask <= PSSI_RST_MASTER;
      st_r.irq_n <= 1'b1;
      st_r.rdata <= PSSI_RST_RDATA;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign mgmt_rdata = st_r.rdata;
  assign irq_out_n = st_r.irq_n;
  assign duplex_led_in_stream = st_r.dup_led;
  assign irq_mode_enable = st_r.mode_en;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_sum_readback: assert property (
    @(posedge mclk) disable iff (!rstn)
    rd_sum |=> mgmt_rdata == $past(sum_word))
    else $error("summary read data mismatch");

  a_pause_and: assert property (
    @(posedge mclk) disable iff (!rstn)
    rd_sum |=> mgmt_rdata[PSSI_SUM_PAUSE]
      == $past(local_pause && partner_pause))
    else $error("pause bit not the and of both ends");

  a_link_low_held: assert property (
    @(posedge mclk) disable iff (!rstn)
    (!link_up && !rd_sum) ##1 (link_up && !rd_sum)[*2]
      |-> !st_r.link_ll)
    else $error("link loss not held until read");

  a_link_read_live: assert property (
    @(posedge mclk) disable iff (!rstn)
    rd_sum |=> st_r.link_ll == $past(link_up))
    else $error("link bit not live after read");

  a_change_latch: assert property (
    @(posedge mclk) disable iff (!rstn)
    (link_up != $past(link_up)) ##1 (!rd_evt)[*3] |-> chg[0])
    else $error("link change not held");

  a_read_clears: assert property (
    @(posedge mclk) disable iff (!rstn)
    (rd_evt && chg_evt == 3'h0) |=> chg == 3'h0)
    else $error("read did not clear change bits");

  a_master_silent: assert property (
    @(posedge mclk) disable iff (!rstn)
    $past(st_r.master_mask) |-> irq_out_n)
    else $error("interrupt while master mask set");

  a_pin_follows: assert property (
    @(posedge mclk) disable iff (!rstn)
    irq_stat |=> !irq_out_n)
    else $error("pin not driven low for pending status");

  a_mask_write: assert property (
    @(posedge mclk) disable iff (!rstn)
    wr_evt |=> st_r.link_mask == $past(mgmt_wdata[PSSI_EVT_LINK_MASK])
      && st_r.dup_mask == $past(mgmt_wdata[PSSI_EVT_DUP_MASK]))
    else $error("mask write not taken");

  a_led_mode: assert property (
    @(posedge mclk) disable iff (!rstn)
    wr_evt ##1 !wr_evt |-> duplex_led_in_stream
      == $past(mgmt_wdata[PSSI_EVT_DUP_LED]))
    else $error("duplex led flag lost");

  a_global_flag: assert property (
    @(posedge mclk) disable iff (!rstn)
    (other_irq && rd_evt) |=> mgmt_rdata[PSSI_EVT_GLOBAL])
    else $error("global pending flag missing");

  a_done_read: assert property (
    @(posedge mclk) disable iff (!rstn)
    rd_sum |=> mgmt_rdata[PSSI_SUM_AN_DONE] == $past(an_done))
    else $error("negotiation done bit wrong on read");

  a_mode_read: assert property (
    @(posedge mclk) disable iff (!rstn)
    rd_sum |=> mgmt_rdata[PSSI_SUM_MODE_HI:PSSI_SUM_MODE_LO]
      == $past(best_common_mode))
    else $error("common mode field wrong on read");

  a_cmpl_ack_held: assert property (
    @(posedge mclk) disable iff (!rstn)
    an_cmpl_ack_evt |=> sum_lh[4])
    else $error("complete-ack event not latched");

  a_pd_fault_held: assert property (
    @(posedge mclk) disable iff (!rstn)
    pd_fault_evt |=> sum_lh[1])
    else $error("parallel detect fault not latched");

  a_page_held: assert property (
    @(posedge mclk) disable iff (!rstn)
    page_rx_evt |=> sum_lh[0])
    else $error("page received not latched");

  a_page_clear: assert property (
    @(posedge mclk) disable iff (!rstn)
    (rd_sum && !page_rx_evt) |=> !sum_lh[0])
    else $error("page received not cleared by read");

  a_remote_read: assert property (
    @(posedge mclk) disable iff (!rstn)
    rd_sum |=> mgmt_rdata[PSSI_SUM_REM_FAULT] == $past(partner_remote_fault))
    else $error("far-end fault bit wrong on read");

  a_able_read: assert property (
    @(posedge mclk) disable iff (!rstn)
    rd_sum |=> mgmt_rdata[PSSI_SUM_LP_AN_ABLE] == $past(partner_an_able))
    else $error("partner able bit wrong on read");

  a_speed_read: assert property (
    @(posedge mclk) disable iff (!rstn)
    rd_sum |=> mgmt_rdata[PSSI_SUM_SPEED] == $past(speed_100)
      && mgmt_rdata[PSSI_SUM_DUPLEX] == $past(full_duplex))
    else $error("speed or duplex bit wrong on read");

  a_mode_en_write: assert property (
    @(posedge mclk) disable iff (!rstn)
    wr_evt |=> irq_mode_enable == $past(mgmt_wdata[PSSI_EVT_MODE_EN]))
    else $error("interrupt mode write not taken");

  a_master_write: assert property (
    @(posedge mclk) disable iff (!rstn)
    wr_evt |=> st_r.master_mask == $past(mgmt_wdata[PSSI_EVT_MASTER]))
    else $error("master mask write not taken");

  a_pin_release: assert property (
    @(posedge mclk) disable iff (!rstn)
    (rd_evt && chg_evt == 3'h0) |-> ##2 irq_out_n)
    else $error("pin not released after read");

  a_unmapped_zero: assert property (
    @(posedge mclk) disable iff (!rstn)
    (mgmt_rd && !rd_sum && !rd_evt) |=> mgmt_rdata == 16'h0000)
    else $error("unmapped read not zero");

  a_rdata_hold: assert property (
    @(posedge mclk) disable iff (!rstn)
    !mgmt_rd |=> $stable(mgmt_rdata))
    else $error("read data moved without a read");

endmodule : pssi_status_irq

// *** verif/pssi_mgmt_model.sv ***
// station management controller model driving the register strobes
`timescale 1ns/1ps
module pssi_mgmt_model
  import pssi_pkg::*;
(
  input wire logic mclk,
  output logic mgmt_rd,
  output logic mgmt_wr,
  output logic [4:0] mgmt_addr,
  output logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata
);
  // ----------------------------------------------------------------
  // strobe tasks, all changes at the falling edge
  // ----------------------------------------------------------------
  initial begin
    mgmt_rd = 1'b0;
    mgmt_wr = 1'b0;
    mgmt_addr = 5'h00;
    mgmt_wdata = 16'h0000;
  end

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge mclk);
    mgmt_rd = 1'b1;
    mgmt_addr = a;
    @(negedge mclk);
    mgmt_rd = 1'b0;
    // released lines show garbage, not the last value
    mgmt_addr = ~a;
    @(negedge mclk);
    d = mgmt_rdata;
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge mclk);
    mgmt_wr = 1'b1;
    mgmt_addr = a;
    mgmt_wdata = d;
    @(negedge mclk);
    mgmt_wr = 1'b0;
    mgmt_addr = ~a;
    mgmt_wdata = ~d;
  endtask : wr

  // keeps reserved and untouched fields as read back
  task automatic rmw(input logic [4:0] a, input logic [15:0] clr,
                     input logic [15:0] set);
    logic [15:0] d;
    rd(a, d);
    wr(a, (d & ~clr) | set);
  endtask : rmw
endmodule : pssi_mgmt_model

// *** verif/tb.sv ***
// self-checking bench for the status summary and event interrupt block
`timescale 1ns/1ps
module tb
  import pssi_pkg::*;
;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic mgmt_rd, mgmt_wr;
  logic [4:0] mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata, d;
  logic an_done = 1'b0, an_cmpl_ack_evt = 1'b0, an_ack_det_evt = 1'b0;
  logic an_abil_det = 1'b0, local_pause = 1'b0, partner_pause = 1'b0;
  logic [2:0] best_common_mode = 3'h0;
  logic pd_fault_evt = 1'b0, partner_remote_fault = 1'b0;
  logic page_rx_evt = 1'b0, partner_an_able = 1'b0;
  logic speed_100 = 1'b0, link_up = 1'b0;
  logic an_enabled = 1'b1, full_duplex = 1'b0, other_irq = 1'b0;
  logic irq_out_n, duplex_led_in_stream, irq_mode_enable;
  int n_mismatch = 0;
  int checks = 0;

  pssi_status_irq pssi_status_irq_i (.mclk(mclk), .rstn(rstn),
    .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr), .mgmt_addr(mgmt_addr),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .an_done(an_done),
    .an_cmpl_ack_evt(an_cmpl_ack_evt), .an_ack_det_evt(an_ack_det_evt),
    .an_abil_det(an_abil_det), .local_pause(local_pause),
    .partner_pause(partner_pause), .best_common_mode(best_common_mode),
    .pd_fault_evt(pd_fault_evt), .partner_remote_fault(partner_remote_fault),
    .page_rx_evt(page_rx_evt), .partner_an_able(partner_an_able),
    .speed_100(speed_100), .link_up(link_up), .an_enabled(an_enabled),
    .full_duplex(full_duplex), .other_irq(other_irq),
    .irq_out_n(irq_out_n), .duplex_led_in_stream(duplex_led_in_stream),
    .irq_mode_enable(irq_mode_enable));

  pssi_mgmt_model pssi_mgmt_model_i (.mclk(mclk), .mgmt_rd(mgmt_rd),
    .mgmt_wr(mgmt_wr), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [15:0] live();
    return {an_done, 3'b000, local_pause & partner_pause, best_common_mode,
            1'b0, partner_remote_fault, 1'b0, partner_an_able, speed_100,
            link_up, an_enabled, full_duplex};
  endfunction : live

  task automatic rd(input logic [4:0] a);
    pssi_mgmt_model_i.rd(a, d);
  endtask : rd

  task automatic toggle(input int i);
    @(negedge mclk);
    case (i)
      0: link_up = ~link_up;
      1: speed_100 = ~speed_100;
      default: full_duplex = ~full_duplex;
    endcase
    // change seen, latched, then pin registered
    repeat (3) @(negedge mclk);
  endtask : toggle

  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(irq_out_n, 1'b1);
    chk({duplex_led_in_stream, irq_mode_enable}, 2'b00);
    rd(PSSI_ADDR_EVT_CTL);
    chk(d, 16'h0F00);
    rd(PSSI_ADDR_SUMMARY);
    chk(d, 16'h0002);
  endtask : t_reset

  task automatic t_live;
    for (int m = 0; m < 6; m++) begin
      @(negedge mclk);
      best_common_mode = 3'(m);
      an_done = m[0];
      local_pause = 1'b1;
      partner_pause = m[1];
      partner_remote_fault = m[2];
      partner_an_able = ~m[0];
      speed_100 = m[1];
      full_duplex = m[0];
      an_enabled = m[2];
      rd(PSSI_ADDR_SUMMARY);
      chk(d, live());
    end
  endtask : t_live

  task automatic t_latch;
    @(negedge mclk);
    {an_cmpl_ack_evt, an_ack_det_evt, an_abil_det} = 3'h7;
    {pd_fault_evt, page_rx_evt} = 2'h3;
    @(negedge mclk);
    {an_cmpl_ack_evt, an_ack_det_evt, an_abil_det} = 3'h0;
    {pd_fault_evt, page_rx_evt} = 2'h0;
    repeat (4) @(negedge mclk);
    rd(PSSI_ADDR_SUMMARY);
    chk(d, live() | 16'h70A0);
    rd(PSSI_ADDR_SUMMARY);
    chk(d, live());
  endtask : t_latch

  task automatic t_link;
    @(negedge mclk);
    link_up = 1'b1;
    rd(PSSI_ADDR_SUMMARY);
    chk(d, live() & 16'hFFFB);
    rd(PSSI_ADDR_SUMMARY);
    chk(d, live());
    @(negedge mclk);
    link_up = 1'b0;
    @(negedge mclk);
    link_up = 1'b1;
    rd(PSSI_ADDR_SUMMARY);
    chk(d, live() & 16'hFFFB);
    rd(PSSI_ADDR_SUMMARY);
    chk(d, live());
  endtask : t_link

  task automatic t_regs;
    pssi_mgmt_model_i.wr(PSSI_ADDR_SUMMARY, 16'hFFFF);
    rd(PSSI_ADDR_SUMMARY);
    chk(d, live());
    rd(5'h05);
    chk(d, 16'h0000);
    rd(PSSI_ADDR_EVT_CTL);
    pssi_mgmt_model_i.wr(PSSI_ADDR_EVT_CTL, 16'hFFFF);
    rd(PSSI_ADDR_EVT_CTL);
    chk(d, 16'hCF00);
    chk({duplex_led_in_stream, irq_mode_enable}, 2'b11);
    pssi_mgmt_model_i.wr(PSSI_ADDR_EVT_CTL, 16'h4F00);
    @(negedge mclk);
    chk({duplex_led_in_stream, irq_mode_enable}, 2'b01);
  endtask : t_regs

  task automatic t_irq;
    for (int i = 0; i < 3; i++) begin
      pssi_mgmt_model_i.rmw(PSSI_ADDR_EVT_CTL, 16'h4F00, 16'h4000);
      toggle(i);
      chk(irq_out_n, 1'b0);
      rd(PSSI_ADDR_EVT_CTL);
      chk(d, 16'h4011 | (16'h0002 << i));
      @(negedge mclk);
      chk(irq_out_n, 1'b1);
      rd(PSSI_ADDR_EVT_CTL);
      chk(d, 16'h4000);
      pssi_mgmt_model_i.rmw(PSSI_ADDR_EVT_CTL, 16'h0000, 16'h0200 << i);
      toggle(i);
      chk(irq_out_n, 1'b1);
      rd(PSSI_ADDR_EVT_CTL);
      chk(d, 16'h4000 | (16'h0200 << i) | (16'h0002 << i));
    end
    pssi_mgmt_model_i.rmw(PSSI_ADDR_EVT_CTL, 16'h0F00, 16'h0100);
    toggle(0);
    chk(irq_out_n, 1'b1);
    other_irq = 1'b1;
    rd(PSSI_ADDR_EVT_CTL);
    chk(d, 16'h4112);
    other_irq = 1'b0;
    pssi_mgmt_model_i.rmw(PSSI_ADDR_EVT_CTL, 16'h4F00, 16'h0000);
    toggle(0);
    chk(irq_out_n, 1'b1);
    rd(PSSI_ADDR_EVT_CTL);
    chk(d, 16'h0002);
  endtask : t_irq

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(negedge mclk);
    rstn = 1'b1;
    t_reset();
    t_live();
    t_latch();
    t_link();
    t_regs();
    t_irq();
    report_and_stop();
  end

  // whole run needs well under a thousand cycles
  initial begin
    #50us;
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb
